// >>> src/tio_pkg.sv
// package for the terminal i/o software-override block: register indices, field layout,
// reset values and value limits shared by the design and the bench.
// assumes a 32-bit apb master; byte address of a register is four times its index.
package tio_pkg;

  // register indices, as printed; the byte address is index * 4
  localparam logic [11:0] IDX_VIRTUAL_INPUT_STATES   = 12'h630;
  localparam logic [11:0] IDX_SOFTWARE_OUTPUT_STATES = 12'h631;
  localparam logic [11:0] IDX_OUT_CFG_ONE            = 12'h611;
  localparam logic [11:0] IDX_OUT_CFG_TWO            = 12'h612;
  localparam logic [11:0] IDX_IN_CFG_BASE            = 12'h620; // four in a row, one each

  localparam int unsigned NUM_IN_TERMS  = 4;
  localparam int unsigned NUM_OUT_TERMS = 2;

  // reset (factory) values
  localparam logic [15:0] VIRTUAL_INPUT_RST   = 16'h0000;
  localparam logic [15:0] SOFTWARE_OUTPUT_RST = 16'h0000;
  localparam logic [15:0] OUT_CFG_ONE_RST     = 16'h0001;
  localparam logic [15:0] OUT_CFG_TWO_RST     = 16'h0002;
  localparam logic [15:0] IN_CFG_RST          = 16'h0000;

  // accepted value limits
  localparam logic [15:0] VIRTUAL_INPUT_MAX   = 16'h03ff;
  localparam logic [15:0] SOFTWARE_OUTPUT_MAX = 16'h003f;
  localparam logic [7:0]  OUT_FUNC_MAX        = 8'h0f;
  localparam logic [7:0]  IN_FUNC_MAX         = 8'h2f;
  localparam logic [7:0]  FUNC_OFF            = 8'h00;

  // field positions of a terminal configuration word (0xWZYX)
  localparam int unsigned CFG_FUNC_LSB = 0;
  localparam int unsigned CFG_POL_LSB  = 8;
  localparam int unsigned CFG_SRC_LSB  = 12;

  // terminal configuration word: source select, polarity, function code
  typedef struct packed {
    logic [3:0] src;   // bit 0: 0 = hardware/function, 1 = software register
    logic [3:0] pol;   // bit 0: 0 = active on, 1 = inverted
    logic [7:0] func;  // function code
  } tio_cfg_s;

  // apb request from the master, published signal names kept
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } tio_apb_req_s;

endpackage : tio_pkg

// >>> src/tio_terminal_io.sv
// terminal i/o software override: apb register file, input terminal source and polarity
// resolution, input function mapping and output terminal source and polarity selection.
// assumes one clock, synchronous inputs and a well-behaved apb master.
//
// Contract
// - an output terminal's function code 00..0f picks which internal function it carries
// - polarity 0 passes the state through, polarity 1 inverts it
// - output source 0 takes the function state, source 1 the software register bit
// - virtual input register bits 0..3 give terminals one to four when sourced by software
// - virtual input register accepts 0x0000..0x03ff only; bits 4..9 carry nothing
// - software output bit 0 drives terminal one, bit 1 terminal two, when selected
// - software output register accepts 0x0000..0x003f only; bits 2..5 drive nothing
// - both software state registers reset to 0x0000
// - input source 0 takes the hardware pin, source 1 the virtual input bit
`timescale 1ns/1ps

module tio_terminal_io #(
  parameter int unsigned NUM_OUT_FUNCS = 16,
  parameter int unsigned NUM_IN_FUNCS  = 48
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire tio_pkg::tio_apb_req_s    apb_req,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire logic [3:0]               phys_in,
  input  wire logic [NUM_OUT_FUNCS-1:0] out_func_states,
  output logic [3:0]                    term_in_state,
  output logic [NUM_IN_FUNCS-1:0]       in_func_states,
  output logic [1:0]                    term_out
);

  // the logic indexes functions by code, so every legal code must have a slot
  if (NUM_OUT_FUNCS < 16 || NUM_OUT_FUNCS > 256) begin : g_chk_out
    $error("NUM_OUT_FUNCS must lie in 16..256");
  end
  if (NUM_IN_FUNCS < 48 || NUM_IN_FUNCS > 256) begin : g_chk_in
    $error("NUM_IN_FUNCS must lie in 48..256");
  end

  localparam logic [15:0] ADDR_VIN    = {2'b00, tio_pkg::IDX_VIRTUAL_INPUT_STATES, 2'b00};
  localparam logic [15:0] ADDR_SWOUT  = {2'b00, tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 2'b00};
  localparam logic [15:0] ADDR_OCFG1  = {2'b00, tio_pkg::IDX_OUT_CFG_ONE, 2'b00};
  localparam logic [15:0] ADDR_OCFG2  = {2'b00, tio_pkg::IDX_OUT_CFG_TWO, 2'b00};
  localparam logic [15:0] ADDR_ICFG0  = {2'b00, tio_pkg::IDX_IN_CFG_BASE, 2'b00};

  // register state
  logic [15:0]       vin_q,   vin_d;
  logic [15:0]       swout_q, swout_d;
  tio_pkg::tio_cfg_s incfg_q  [4];
  tio_pkg::tio_cfg_s incfg_d  [4];
  tio_pkg::tio_cfg_s outcfg_q [2];
  tio_pkg::tio_cfg_s outcfg_d [2];
  logic [31:0]       prdata_q, prdata_d;
  logic              pslverr_q, pslverr_d;

  // terminal state
  logic [3:0]              term_in_q,  term_in_d;
  logic [NUM_IN_FUNCS-1:0] in_func_q,  in_func_d;
  logic [1:0]              term_out_q, term_out_d;

  // decode of the held request
  logic        setup_ph;
  logic        acc_ph;
  logic        wr_fire;
  logic        hit;
  logic        wr_ok;
  logic [31:0] rd_val;
  logic [15:0] wdat;

  // a configuration word is legal when each field is inside its range
  function automatic logic cfg_ok(input logic [15:0] v, input logic [7:0] fmax);
    cfg_ok = (v[7:0] <= fmax) && (v[11:9] == 3'h0) && (v[15:13] == 3'h0);
  endfunction

  // zero wait states; ce low stalls the access phase, but if ce is low at the edge ending setup the old read data and error are returned
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign acc_ph   = apb_req.psel && apb_req.penable;
  assign pready   = acc_ph && ce;
  assign wr_fire  = pready && apb_req.pwrite;
  assign wdat     = apb_req.pwdata[15:0];
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;

  // address decode, read mux and write legality check
  always_comb begin
    hit    = 1'b1;
    wr_ok  = 1'b0;
    rd_val = 32'h0000_0000;
    if (apb_req.paddr == ADDR_VIN) begin
      rd_val = {16'h0000, vin_q};
      wr_ok  = (apb_req.pwdata <= {16'h0000, tio_pkg::VIRTUAL_INPUT_MAX});
    end else if (apb_req.paddr == ADDR_SWOUT) begin
      rd_val = {16'h0000, swout_q};
      wr_ok  = (apb_req.pwdata <= {16'h0000, tio_pkg::SOFTWARE_OUTPUT_MAX});
    end else if (apb_req.paddr == ADDR_OCFG1) begin
      rd_val = {16'h0000, outcfg_q[0]};
      wr_ok  = (apb_req.pwdata[31:16] == 16'h0000) && cfg_ok(wdat, tio_pkg::OUT_FUNC_MAX);
    end else if (apb_req.paddr == ADDR_OCFG2) begin
      rd_val = {16'h0000, outcfg_q[1]};
      wr_ok  = (apb_req.pwdata[31:16] == 16'h0000) && cfg_ok(wdat, tio_pkg::OUT_FUNC_MAX);
    end else if (apb_req.paddr[15:4] == ADDR_ICFG0[15:4] && apb_req.paddr[1:0] == 2'b00) begin
      rd_val = {16'h0000, incfg_q[apb_req.paddr[3:2]]};
      wr_ok  = (apb_req.pwdata[31:16] == 16'h0000) && cfg_ok(wdat, tio_pkg::IN_FUNC_MAX);
    end else begin
      hit = 1'b0;
    end
  end

  // register next values; an illegal value is refused whole and the old one kept
  always_comb begin
    vin_d     = vin_q;
    swout_d   = swout_q;
    incfg_d   = incfg_q;
    outcfg_d  = outcfg_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_ph) begin
      // read data and error are caught in setup so both come from flip-flops in access
      prdata_d  = apb_req.pwrite ? 32'h0000_0000 : rd_val;
      pslverr_d = !hit || (apb_req.pwrite && !wr_ok);
    end
    if (wr_fire && hit && wr_ok) begin
      if (apb_req.paddr == ADDR_VIN) begin
        vin_d = wdat;
      end else if (apb_req.paddr == ADDR_SWOUT) begin
        swout_d = wdat;
      end else if (apb_req.paddr == ADDR_OCFG1) begin
        outcfg_d[0] = wdat;
      end else if (apb_req.paddr == ADDR_OCFG2) begin
        outcfg_d[1] = wdat;
      end else begin
        incfg_d[apb_req.paddr[3:2]] = wdat;
      end
    end
  end

  // register file flops; ce low freezes everything
  always_ff @(posedge clk) begin
    if (!rstn) begin
      vin_q       <= tio_pkg::VIRTUAL_INPUT_RST;
      swout_q     <= tio_pkg::SOFTWARE_OUTPUT_RST;
      outcfg_q[0] <= tio_pkg::OUT_CFG_ONE_RST;
      outcfg_q[1] <= tio_pkg::OUT_CFG_TWO_RST;
      for (int i = 0; i < 4; i++) begin
        incfg_q[i] <= tio_pkg::IN_CFG_RST;
      end
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      vin_q     <= vin_d;
      swout_q   <= swout_d;
      incfg_q   <= incfg_d;
      outcfg_q  <= outcfg_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // terminal resolution; only bits 0..3 and 0..1 of the software registers are looked at
  always_comb begin
    logic raw;
    raw       = 1'b0;
    in_func_d = '0;
    for (int i = 0; i < 4; i++) begin
      raw          = incfg_q[i].src[0] ? vin_q[i] : phys_in[i];
      term_in_d[i] = raw ^ incfg_q[i].pol[0];
      // code 00 is off: a terminal so set feeds no function
      if (term_in_d[i] && incfg_q[i].func != tio_pkg::FUNC_OFF) begin
        in_func_d[incfg_q[i].func[5:0]] = 1'b1;
      end
    end
    for (int j = 0; j < 2; j++) begin
      raw = outcfg_q[j].src[0] ? swout_q[j] : out_func_states[outcfg_q[j].func[3:0]];
      term_out_d[j] = raw ^ outcfg_q[j].pol[0];
    end
  end

  // terminal flops: a register written at one edge shows on the terminals one edge later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      term_in_q  <= 4'h0;
      in_func_q  <= '0;
      term_out_q <= 2'h0;
    end else if (ce) begin
      term_in_q  <= term_in_d;
      in_func_q  <= in_func_d;
      term_out_q <= term_out_d;
    end
  end

  assign term_in_state  = term_in_q;
  assign in_func_states = in_func_q;
  assign term_out       = term_out_q;

  // helper values for the checks below, written independently of the datapath
  logic y1_func_raw;
  logic y2_sw_raw;
  logic x1_pin_raw;
  logic x2_vin_raw;
  assign y1_func_raw = out_func_states[outcfg_q[0].func[3:0]] ^ outcfg_q[0].pol[0];
  assign y2_sw_raw   = swout_q[1] ^ outcfg_q[1].pol[0];
  assign x1_pin_raw  = phys_in[0] ^ incfg_q[0].pol[0];
  assign x2_vin_raw  = vin_q[1] ^ incfg_q[1].pol[0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // out-of-range writes leave the software registers untouched
  a_vin_range_keep: assert property (
    wr_fire && apb_req.paddr == ADDR_VIN && apb_req.pwdata > 32'h0000_03ff
    |=> $stable(vin_q) && pslverr_q == $past(pslverr_q))
    else $error("virtual input register took an out-of-range value");

  a_swout_range_keep: assert property (
    wr_fire && apb_req.paddr == ADDR_SWOUT && apb_req.pwdata > 32'h0000_003f
    |=> $stable(swout_q))
    else $error("software output register took an out-of-range value");

  a_sw_reset_zero: assert property (
    $rose(rstn) |-> vin_q == 16'h0000 && swout_q == 16'h0000 && term_out_q == 2'h0)
    else $error("software state registers not zero after reset");

  a_in_pin_source: assert property (
    ce && !incfg_q[0].src[0] |=> term_in_q[0] == $past(x1_pin_raw))
    else $error("input terminal one did not follow its pin");

  a_in_virtual_src: assert property (
    ce && incfg_q[1].src[0] |=> term_in_q[1] == $past(x2_vin_raw))
    else $error("input terminal two did not follow virtual bit 1");

  a_out_func_src: assert property (
    ce && !outcfg_q[0].src[0] |=> term_out_q[0] == $past(y1_func_raw))
    else $error("output terminal one did not carry its function");

  a_out_soft_src: assert property (
    ce && outcfg_q[1].src[0] |=> term_out_q[1] == $past(y2_sw_raw))
    else $error("output terminal two did not follow software bit 1");

  a_out_polarity_inv: assert property (
    ce && outcfg_q[0].src[0] && outcfg_q[0].pol[0] && swout_q[0] |=> !term_out_q[0])
    else $error("inverted output terminal one not inverted");

  sequence s_swout_set_y2;
    wr_fire && apb_req.paddr == ADDR_SWOUT && apb_req.pwdata == 32'h0000_0002;
  endsequence

  sequence s_y2_plain_soft;
    ce && outcfg_q[1].src[0] && !outcfg_q[1].pol[0];
  endsequence

  a_write_next_update: assert property (
    s_swout_set_y2 ##1 s_y2_plain_soft |=> term_out_q == {1'b1, $past(term_out_d[0])})
    else $error("software output write missed the next update");

endmodule // tio_terminal_io

// >>> tb/tio_switch_model.sv
// terminal-side model: contacts on the input pins and loads on the output terminals.
// assumes the bench commands switch closure; a closed contact reads high.
`timescale 1ns/1ps

module tio_switch_model (
  input  wire logic       clk,
  input  wire logic [3:0] sw_closed,
  input  wire logic [1:0] term_out,
  output logic      [3:0] phys_in,
  output logic      [1:0] load_on
);
  // contact settles one cycle after the command, like a real switch seen by a sync input
  always_ff @(posedge clk) begin
    phys_in <= sw_closed;
  end

  // loads simply follow the terminal level
  assign load_on = term_out;
endmodule // tio_switch_model

// >>> tb/tio_terminal_io_tb_top.sv
// bench for the terminal i/o block: apb register tasks, terminal checks, verdict.
// assumes zero-wait apb from the design and the terminal-side model beside it.
`timescale 1ns/1ps

module tio_terminal_io_tb_top;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 ce = 1'b1;
  tio_pkg::tio_apb_req_s req = '0;
  logic                 pready;
  logic          [31:0] prdata;
  logic                 pslverr;
  logic           [3:0] phys_in;
  logic           [3:0] sw = 4'h0;
  logic          [15:0] ofs = 16'h0000;
  logic           [3:0] term_in_state;
  logic          [47:0] in_func_states;
  logic           [1:0] term_out;
  logic           [1:0] load_on;
  int                   error_cnt = 0;
  int                   comparisons = 0;
  logic          [31:0] rd;
  logic                 er;

  tio_terminal_io i_tio_terminal_io (.clk(clk), .rstn(rstn), .ce(ce), .apb_req(req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .phys_in(phys_in),
    .out_func_states(ofs), .term_in_state(term_in_state), .in_func_states(in_func_states),
    .term_out(term_out));
  tio_switch_model i_tio_switch_model (.clk(clk), .sw_closed(sw), .term_out(term_out),
    .phys_in(phys_in), .load_on(load_on));

  initial begin
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] adr(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    // no cycle count is assumed here: only the watchdog ends a stalled wait
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic exp_err);
    apb(1'b1, adr(i), d);
    chk(er, exp_err);
  endtask

  task automatic rdc(input logic [11:0] i, input logic [31:0] exp);
    apb(1'b0, adr(i), 32'h0);
    chk(rd, exp);
  endtask

  // wait for the terminal path, then sample off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdc(tio_pkg::IDX_VIRTUAL_INPUT_STATES, 32'h0);
    rdc(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h0);
    rdc(tio_pkg::IDX_OUT_CFG_ONE, 32'h1);
    // range limits: top value kept, one above refused and register untouched
    wr(tio_pkg::IDX_VIRTUAL_INPUT_STATES, 32'h3ff, 1'b0);
    wr(tio_pkg::IDX_VIRTUAL_INPUT_STATES, 32'h400, 1'b1);
    rdc(tio_pkg::IDX_VIRTUAL_INPUT_STATES, 32'h3ff);
    wr(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h3f, 1'b0);
    wr(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h40, 1'b1);
    wr(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h10000, 1'b1);
    rdc(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h3f);
    apb(1'b0, 16'h0000, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    // inputs from software, codes 1..4 on terminals one..four
    for (int i = 0; i < 4; i++) wr(tio_pkg::IDX_IN_CFG_BASE + 12'(i), 32'h1000 | (i + 1), 1'b0);
    wr(tio_pkg::IDX_VIRTUAL_INPUT_STATES, 32'h0f5, 1'b0);
    settle(1);
    chk(term_in_state, 4'h5);
    chk(in_func_states, 48'h0a);
    wr(tio_pkg::IDX_IN_CFG_BASE, 32'h1101, 1'b0);
    settle(2);
    chk(term_in_state, 4'h4);
    chk(in_func_states, 48'h08);
    // inputs from the pins; the switch changes on the edge that ends the last write
    for (int i = 0; i < 4; i++) wr(tio_pkg::IDX_IN_CFG_BASE + 12'(i), 32'(i + 1), 1'b0);
    sw <= 4'h6;
    settle(2);
    chk(term_in_state, 4'h6);
    chk(in_func_states, 48'h0c);
    // outputs from the software register; reserved bits drive nothing
    wr(tio_pkg::IDX_OUT_CFG_ONE, 32'h1000, 1'b0);
    wr(tio_pkg::IDX_OUT_CFG_TWO, 32'h1000, 1'b0);
    wr(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h3d, 1'b0);
    settle(1);
    chk(load_on, 2'b01);
    wr(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h02, 1'b0);
    settle(2);
    chk(load_on, 2'b10);
    // every output function code, terminal two inverted
    for (int k = 0; k < 16; k++) begin
      wr(tio_pkg::IDX_OUT_CFG_ONE, 32'(k), 1'b0);
      wr(tio_pkg::IDX_OUT_CFG_TWO, 32'h100 | k, 1'b0);
      ofs <= 16'h1 << k;
      settle(2);
      chk(load_on, 2'b01);
      @(posedge clk);
      ofs <= ~(16'h1 << k);
      settle(2);
      chk(load_on, 2'b10);
    end
    wr(tio_pkg::IDX_OUT_CFG_ONE, 32'h10, 1'b1);
    // terminal one from software and inverted: a set bit drives the terminal low
    wr(tio_pkg::IDX_OUT_CFG_ONE, 32'h1100, 1'b0);
    wr(tio_pkg::IDX_SOFTWARE_OUTPUT_STATES, 32'h01, 1'b0);
    settle(2);
    chk(load_on, 2'b10);
    // clock enable low freezes the terminals although the pins move
    @(posedge clk);
    ce <= 1'b0;
    sw <= 4'h9;
    settle(3);
    chk(term_in_state, 4'h6);
    @(posedge clk);
    ce <= 1'b1;
    settle(1);
    chk(term_in_state, 4'h9);
    chk(in_func_states, 48'h12);
    stop_test();
  end
endmodule // tio_terminal_io_tb_top
